// >>> include/fgd_defines.vh
`ifndef FGD_DEFINES_VH
`define FGD_DEFINES_VH

// ==========================================================
// Register byte offsets
`define FGD_OFS_CTRL    8'h00
`define FGD_OFS_KEY     8'h04
`define FGD_OFS_GUARD   8'h08
`define FGD_OFS_ADDR    8'h0c
`define FGD_OFS_IRQ_ST  8'h10
`define FGD_OFS_IRQ_MSK 8'h14

// ==========================================================
// Control register fields
`define FGD_CTRL_GO     15
`define FGD_CTRL_ARM    14
`define FGD_CTRL_FAIL   13
`define FGD_CTRL_LOW    12
`define FGD_CTRL_OP_HI  3
`define FGD_CTRL_OP_LO  0
`define FGD_OP_NOP      4'h0

// ==========================================================
// Boot page guard fields
`define FGD_GRD_UNLATCH 15
`define FGD_GRD_P2      10
`define FGD_GRD_P1      9
`define FGD_GRD_P0      8
`define FGD_GRD_RESET   3'h7

// ==========================================================
// Guarded physical address windows, inclusive
`define FGD_P2_LO 32'h1fc00000
`define FGD_P2_HI 32'h1fc007ff
`define FGD_P1_LO 32'h1fc00800
`define FGD_P1_HI 32'h1fc00fff
`define FGD_P0_LO 32'h1fc01000
`define FGD_P0_HI 32'h1fc017ff

// ==========================================================
// Interrupt status and mask bits
`define FGD_IRQ_DONE 0
`define FGD_IRQ_FAIL 1
`define FGD_IRQ_LOW  2
`define FGD_IRQ_W    3

`endif

// >>> rtl/fgd_unlock.v
`timescale 1ns/1ps
`include "fgd_defines.vh"

module fgd_unlock
#(
  parameter [31:0] KEY_FIRST  = 32'h0000a5a5,
  parameter [31:0] KEY_SECOND = 32'h00005a5a
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire        key_wr,
  input  wire [31:0] key_data,
  input  wire        consume,
  output wire        unlocked
);

// ==========================================================
// Sequence states
localparam [2:0] S_LOCK = 3'h1;
localparam [2:0] S_HALF = 3'h2;
localparam [2:0] S_OPEN = 3'h4;

reg [2:0] state;

assign unlocked = state[2];

// ==========================================================
// Two back-to-back key writes open one protected write
always @(posedge clk)
begin
  if (rst)
    state <= S_LOCK;
  else
  begin
    case (state)
      S_LOCK:
        if (key_wr && key_data == KEY_FIRST)
          state <= S_HALF;
      S_HALF:
        if (key_wr && key_data == KEY_SECOND)
          state <= S_OPEN;
        else if (key_wr || consume)
          state <= S_LOCK;
      S_OPEN:
        // Any later write closes it, so a stray key cannot reopen
        if (key_wr || consume)
          state <= S_LOCK;
      default:
        state <= S_LOCK;
    endcase
  end
end

endmodule // fgd_unlock

// >>> rtl/fgd_flash_ctrl.v
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "fgd_defines.vh"

// Function
// (RQ1) Go sets only with arm high right after unlock; writing 0 ignored.
// (RQ2) Go starts the operation, reads 1 while running, 0 when done.
// (RQ3) Arm high: go writable, op code frozen; arm low: the reverse.
// (RQ4) Fail flag set when program or erase fails, else untouched.
// (RQ5) Low-supply flag set when supply sags during an operation.
// (RQ6) Both flags clear only by starting op code 0000.
// (RQ7) Go, arm and both flags reset only by power-on reset.
// (RQ8) Bit 11 kept 0 by software; unused bits read 0.
// (RQ9) Guard register writes need the key unlock sequence first.
// (RQ10) Page guard bits writable only while unlatch bit is 1.
// (RQ11) Unlatch bit clear-only; any reset sets it back to 1.
// (RQ12) Page 2 guard blocks writes to 1fc00000..1fc007ff.
// (RQ13) Page 1 guard blocks writes to 1fc00800..1fc00fff.
// (RQ14) Page 0 guard blocks writes to 1fc01000..1fc017ff.
// (RQ15) Go stays set all operation, clears as flags are final.
module fgd_flash_ctrl
#(
  parameter [31:0] KEY_FIRST  = 32'h0000a5a5,
  parameter [31:0] KEY_SECOND = 32'h00005a5a
)
(
  input  wire        MCLK,
  input  wire        RST,
  input  wire        POR,
  input  wire [7:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [3:0]  AVS_BYTEENABLE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  output reg         FLASH_START,
  output reg  [3:0]  FLASH_OP,
  output reg  [31:0] FLASH_ADDR,
  input  wire        FLASH_DONE,
  input  wire        FLASH_FAIL,
  input  wire        LOW_SUPPLY,
  output wire        IRQ
);

// ==========================================================
// Sequencer states
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_RUN  = 3'h2;
localparam [2:0] ST_END  = 3'h4;

// ==========================================================
// Storage
reg                 ack;
reg                 go;
reg                 arm;
reg                 fail;
reg                 low;
reg  [3:0]          op;
reg                 unlatch;
reg  [2:0]          pages;
reg  [31:0]         faddr;
reg  [2:0]          state;
reg                 blocked;
reg  [`FGD_IRQ_W-1:0] irq_st;
reg  [`FGD_IRQ_W-1:0] irq_msk;
reg  [`FGD_IRQ_W-1:0] irq_rd;
reg  [`FGD_IRQ_W-1:0] events;
reg  [31:0]         next_rdata;

wire                req;
wire                wr_acc;
wire                rd_acc;
wire                wr_ctrl;
wire                wr_key;
wire                wr_guard;
wire                wr_addr;
wire                wr_msk;
wire                unlocked;
wire                go_req;
wire                hit;
wire                any_reset;

// ==========================================================
// Helpers
function in_page;
  input [31:0] a;
  input [31:0] lo;
  input [31:0] hi;
  begin
    in_page = (a >= lo) && (a <= hi);
  end
endfunction

function sel;
  input [7:0] a;
  input [7:0] ofs;
  begin
    sel = (a == ofs);
  end
endfunction

// ==========================================================
// Avalon slave: one wait cycle, answer on second edge
assign req             = AVS_READ | AVS_WRITE;
assign AVS_WAITREQUEST = req & ~ack;
assign wr_acc          = AVS_WRITE & ack;
assign rd_acc          = AVS_READ & ack;
assign wr_ctrl         = wr_acc & sel(AVS_ADDRESS, `FGD_OFS_CTRL);
assign wr_key          = wr_acc & sel(AVS_ADDRESS, `FGD_OFS_KEY);
assign wr_guard        = wr_acc & sel(AVS_ADDRESS, `FGD_OFS_GUARD);
assign wr_addr         = wr_acc & sel(AVS_ADDRESS, `FGD_OFS_ADDR);
assign wr_msk          = wr_acc & sel(AVS_ADDRESS, `FGD_OFS_IRQ_MSK);
assign any_reset       = RST | POR;

always @(posedge MCLK)
begin
  if (any_reset)
    ack <= 1'b0;
  else
    ack <= req & ~ack;
end

// Read data is latched on the first edge and stands at the second
always @*
begin
  next_rdata = 32'h00000000;
  if (sel(AVS_ADDRESS, `FGD_OFS_CTRL))
  begin
    next_rdata[`FGD_CTRL_GO]   = go;                           // RQ2
    next_rdata[`FGD_CTRL_ARM]  = arm;
    next_rdata[`FGD_CTRL_FAIL] = fail;
    next_rdata[`FGD_CTRL_LOW]  = low;
    next_rdata[`FGD_CTRL_OP_HI:`FGD_CTRL_OP_LO] = op;          // RQ8
  end
  else if (sel(AVS_ADDRESS, `FGD_OFS_GUARD))
  begin
    next_rdata[`FGD_GRD_UNLATCH] = unlatch;
    next_rdata[`FGD_GRD_P2]      = pages[2];
    next_rdata[`FGD_GRD_P1]      = pages[1];
    next_rdata[`FGD_GRD_P0]      = pages[0];
  end
  else if (sel(AVS_ADDRESS, `FGD_OFS_ADDR))
    next_rdata = faddr;
  else if (sel(AVS_ADDRESS, `FGD_OFS_IRQ_ST))
    next_rdata[`FGD_IRQ_W-1:0] = irq_st;
  else if (sel(AVS_ADDRESS, `FGD_OFS_IRQ_MSK))
    next_rdata[`FGD_IRQ_W-1:0] = irq_msk;
end

always @(posedge MCLK)
begin
  if (any_reset)
  begin
    AVS_READDATA <= 32'h00000000;
    irq_rd       <= {`FGD_IRQ_W{1'b0}};
  end
  else if (AVS_READ && !ack)
  begin
    AVS_READDATA <= next_rdata;
    // Only the bits actually returned are cleared later
    if (sel(AVS_ADDRESS, `FGD_OFS_IRQ_ST))
      irq_rd <= irq_st;
    else
      irq_rd <= {`FGD_IRQ_W{1'b0}};
  end
end

// ==========================================================
// Unlock sequence; any other accepted write uses it up
fgd_unlock
#(
  .KEY_FIRST  (KEY_FIRST),
  .KEY_SECOND (KEY_SECOND)
)
u_unlock
(
  .clk      (MCLK),
  .rst      (any_reset),
  .key_wr   (wr_key),
  .key_data (AVS_WRITEDATA),
  .consume  (wr_acc & ~wr_key),
  .unlocked (unlocked)
);

// ==========================================================
// Control register and sequencer
assign go_req = wr_ctrl & AVS_BYTEENABLE[1]
              & AVS_WRITEDATA[`FGD_CTRL_GO]
              & arm & unlocked & ~go;                          // RQ1

// Address protection is judged at start, on the latched address
assign hit = (pages[2] & in_page(faddr, `FGD_P2_LO, `FGD_P2_HI)) // RQ12
           | (pages[1] & in_page(faddr, `FGD_P1_LO, `FGD_P1_HI)) // RQ13
           | (pages[0] & in_page(faddr, `FGD_P0_LO, `FGD_P0_HI)); // RQ14

// Other resets leave this group alone so errors survive a crash
always @(posedge MCLK)
begin
  if (POR)                                                     // RQ7
  begin
    go      <= 1'b0;
    arm     <= 1'b0;
    fail    <= 1'b0;
    low     <= 1'b0;
    op      <= `FGD_OP_NOP;
    state   <= ST_IDLE;
    blocked <= 1'b0;
  end
  else
  begin
    if (wr_ctrl && AVS_BYTEENABLE[1])
      arm <= AVS_WRITEDATA[`FGD_CTRL_ARM];
    if (wr_ctrl && AVS_BYTEENABLE[0] && !arm && !go)           // RQ3
      op <= AVS_WRITEDATA[`FGD_CTRL_OP_HI:`FGD_CTRL_OP_LO];
    case (state)
      ST_IDLE:
        if (go_req)
        begin
          go <= 1'b1;                                          // RQ2
          if (op == `FGD_OP_NOP || hit)
          begin
            blocked <= hit && op != `FGD_OP_NOP;
            state   <= ST_END;
          end
          else
            state <= ST_RUN;
        end
      ST_RUN:
      begin
        if (LOW_SUPPLY)
          low <= 1'b1;                                         // RQ5
        if (FLASH_DONE)
        begin
          go <= 1'b0;                                          // RQ15
          if (FLASH_FAIL)
            fail <= 1'b1;                                      // RQ4
          state <= ST_IDLE;
        end
      end
      ST_END:
      begin
        go <= 1'b0;                                            // RQ15
        if (blocked)
          fail <= 1'b1;
        else
        begin
          fail <= 1'b0;                                        // RQ6
          low  <= 1'b0;                                        // RQ6
        end
        blocked <= 1'b0;
        state   <= ST_IDLE;
      end
      default:
      begin
        go    <= 1'b0;
        state <= ST_IDLE;
      end
    endcase
  end
end

// ==========================================================
// Flash array side
always @(posedge MCLK)
begin
  if (any_reset)
  begin
    FLASH_START <= 1'b0;
    FLASH_OP    <= `FGD_OP_NOP;
    FLASH_ADDR  <= 32'h00000000;
  end
  else
  begin
    FLASH_START <= state[0] & go_req & (op != `FGD_OP_NOP) & ~hit;
    if (state[0] && go_req)
    begin
      FLASH_OP   <= op;
      FLASH_ADDR <= faddr;
    end
  end
end

// Target address is frozen while an operation runs
always @(posedge MCLK)
begin
  if (any_reset)
    faddr <= 32'h00000000;
  else if (wr_addr && !go)
    faddr <= AVS_WRITEDATA;
end

// ==========================================================
// Boot page guard
always @(posedge MCLK)
begin
  if (any_reset)
  begin
    unlatch <= 1'b1;                                           // RQ11
    pages   <= `FGD_GRD_RESET;
  end
  else if (wr_guard && unlocked && AVS_BYTEENABLE[1])          // RQ9
  begin
    if (!AVS_WRITEDATA[`FGD_GRD_UNLATCH])
      unlatch <= 1'b0;                                         // RQ11
    if (unlatch)                                               // RQ10
    begin
      pages[2] <= AVS_WRITEDATA[`FGD_GRD_P2];
      pages[1] <= AVS_WRITEDATA[`FGD_GRD_P1];
      pages[0] <= AVS_WRITEDATA[`FGD_GRD_P0];
    end
  end
end

// ==========================================================
// Interrupts: new events win over the read clear
always @*
begin
  events = {`FGD_IRQ_W{1'b0}};
  events[`FGD_IRQ_DONE] = (state[1] & FLASH_DONE) | state[2];
  events[`FGD_IRQ_FAIL] = (state[1] & FLASH_DONE & FLASH_FAIL)
                        | (state[2] & blocked);
  events[`FGD_IRQ_LOW]  = state[1] & LOW_SUPPLY & ~low;
end

always @(posedge MCLK)
begin
  if (any_reset)
  begin
    irq_st  <= {`FGD_IRQ_W{1'b0}};
    irq_msk <= {`FGD_IRQ_W{1'b0}};
  end
  else
  begin
    if (rd_acc && sel(AVS_ADDRESS, `FGD_OFS_IRQ_ST))
      irq_st <= (irq_st & ~irq_rd) | events;
    else
      irq_st <= irq_st | events;
    if (wr_msk && AVS_BYTEENABLE[0])
      irq_msk <= AVS_WRITEDATA[`FGD_IRQ_W-1:0];
  end
end

assign IRQ = |(irq_st & irq_msk);

endmodule // fgd_flash_ctrl

// >>> test/fgd_array.sv
`timescale 1ns/1ps
// ========
// Flash array model
module fgd_array
(
  input  wire       clk,
  input  wire       rst,
  input  wire       start,
  input  wire [3:0] lat,
  input  wire       bad,
  output reg        done,
  output reg        fail
);
  reg [3:0] cnt;
  always @(posedge clk)
  begin
    cnt  <= rst ? 4'h0 : start ? lat : (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
    done <= ~rst & (cnt == 4'h1);
    // Junk outside done, so a stale result is never trusted
    fail <= rst ? 1'b0 : (cnt == 4'h1) ? bad : ~fail;
  end
endmodule // fgd_array

// >>> test/fgd_flash_ctrl_monitor.sv
`timescale 1ns/1ps
// ========
// Port checker
module fgd_flash_ctrl_monitor
(
  input wire        MCLK,
  input wire        RST,
  input wire        POR,
  input wire [7:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire        FLASH_START,
  input wire        FLASH_DONE
);
  reg  run;
  wire rd0 = AVS_READ & ~AVS_WAITREQUEST & (AVS_ADDRESS == 8'h00);
  wire rd4 = AVS_READ & ~AVS_WAITREQUEST & (AVS_ADDRESS == 8'h04);
  wire rd8 = AVS_READ & ~AVS_WAITREQUEST & (AVS_ADDRESS == 8'h08);
  wire go_acc = AVS_WRITE & ~AVS_WAITREQUEST & (AVS_ADDRESS == 8'h00)
              & AVS_WRITEDATA[15];
  // Tracks a live operation; done or power-on reset drops it, RST does not
  always @(posedge MCLK)
    run <= POR ? 1'b0 : FLASH_START ? 1'b1 : FLASH_DONE ? 1'b0 : run;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST || POR);
  chk_start_pulse:
    assert property (FLASH_START |=> !FLASH_START) else $error("long start");
  chk_start_cause:
    assert property (FLASH_START |-> $past(go_acc))
      else $error("start without go write");
  chk_start_idle:
    assert property (run |-> !FLASH_START) else $error("restart while busy");
  chk_go_busy:
    assert property (rd0 && run |-> AVS_READDATA[15])
      else $error("go low while busy");
  chk_ctrl_zero:
    assert property (rd0 |-> AVS_READDATA[31:16] == 16'h0
      && AVS_READDATA[11:4] == 8'h00) else $error("ctrl spare bits set");
  chk_guard_zero:
    assert property (rd8 |-> AVS_READDATA[31:16] == 16'h0
      && AVS_READDATA[14:11] == 4'h0 && AVS_READDATA[7:0] == 8'h00)
      else $error("guard spare bits set");
  chk_key_zero:
    assert property (rd4 |-> AVS_READDATA == 32'h0) else $error("key read");
  chk_wait_one:
    assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST) else $error("wait not single");
endmodule // fgd_flash_ctrl_monitor

bind fgd_flash_ctrl fgd_flash_ctrl_monitor u_mon (.MCLK(MCLK), .RST(RST),
  .POR(POR), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .FLASH_START(FLASH_START), .FLASH_DONE(FLASH_DONE));

// >>> test/flash_op_control_boot_guard_bench.sv
`timescale 1ns/1ps
// ========
// Bench
module flash_op_control_boot_guard_bench;
  reg         MCLK = 1'b0;
  reg         RST = 1'b1;
  reg         POR = 1'b1;
  reg  [7:0]  AVS_ADDRESS = 8'h00;
  reg         AVS_READ = 1'b0;
  reg         AVS_WRITE = 1'b0;
  reg  [3:0]  AVS_BYTEENABLE = 4'hf;
  reg  [31:0] AVS_WRITEDATA = 32'h0;
  reg         LOW_SUPPLY = 1'b0;
  reg         bad = 1'b0;
  reg  [3:0]  lat = 4'h2;
  wire [31:0] AVS_READDATA;
  wire        AVS_WAITREQUEST;
  wire        FLASH_START;
  wire [3:0]  FLASH_OP;
  wire [31:0] FLASH_ADDR;
  wire        FLASH_DONE;
  wire        FLASH_FAIL;
  wire        IRQ;
  integer     n_fail = 0;
  integer     samples_checked = 0;
  integer     n_start = 0;
  integer     s;
  integer     k;
  reg  [31:0] d;
  logic [31:0] tbl [0:6] = '{32'h1fc00000, 32'h1fc007ff, 32'h1fc00800,
    32'h1fc00fff, 32'h1fc01000, 32'h1fc017ff, 32'h1fc01800};
  always #2 MCLK = ~MCLK;
  always @(posedge MCLK)
    if (FLASH_START === 1'b1)
      n_start <= n_start + 1;
  fgd_flash_ctrl #(.KEY_FIRST(32'h0000a5a5), .KEY_SECOND(32'h00005a5a)) DUT
  (.MCLK(MCLK), .RST(RST), .POR(POR), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .FLASH_START(FLASH_START), .FLASH_OP(FLASH_OP), .FLASH_ADDR(FLASH_ADDR),
   .FLASH_DONE(FLASH_DONE), .FLASH_FAIL(FLASH_FAIL),
   .LOW_SUPPLY(LOW_SUPPLY), .IRQ(IRQ));
  fgd_array u_array (.clk(MCLK), .rst(POR), .start(FLASH_START), .lat(lat),
    .bad(bad), .done(FLASH_DONE), .fail(FLASH_FAIL));
  task wrap_up;
  begin
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // Request held until waitrequest is seen low at an edge
  task xfer(input w, input [7:0] a, input [31:0] wd);
    integer i;
  begin
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    i = 0;
    @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0 && i < 20)
    begin
      @(posedge MCLK);
      i = i + 1;
    end
    d = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (i == 20)
    begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  endtask
  task unl;
  begin
    xfer(1'b1, 8'h04, 32'h0000a5a5);
    xfer(1'b1, 8'h04, 32'h00005a5a);
  end
  endtask
  // Op code is loaded with arm low, since arm freezes it
  task go_op(input [31:0] a, input [3:0] c);
  begin
    xfer(1'b1, 8'h0c, a);
    xfer(1'b1, 8'h00, {28'h0, c});
    xfer(1'b1, 8'h00, {16'h0, 4'h4, 8'h0, c});
    unl;
    xfer(1'b1, 8'h00, {16'h0, 4'hc, 8'h0, c});
  end
  endtask
  task idle;
    integer i;
  begin
    i = 0;
    d = 32'h8000;
    while (d[15] !== 1'b0 && i < 40)
    begin
      xfer(1'b0, 8'h00, 32'h0);
      i = i + 1;
    end
    if (i == 40)
    begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  endtask
  task pulse_rst;
  begin
    @(posedge MCLK);
    RST <= 1'b1;
    @(posedge MCLK);
    RST <= 1'b0;
  end
  endtask
  task t_reset;
  begin
    xfer(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h0, d);
    xfer(1'b0, 8'h08, 32'h0);
    chk("guard", 32'h8700, d);
    xfer(1'b0, 8'h04, 32'h0);
    xfer(1'b1, 8'h20, 32'hffffffff);
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, d);
    $display("t_reset done");
  end
  endtask
  task t_arm;
  begin
    xfer(1'b1, 8'h00, 32'h1);
    xfer(1'b1, 8'h00, 32'h4002);
    xfer(1'b1, 8'h00, 32'hc001);
    xfer(1'b0, 8'h00, 32'h0);
    chk("arm", 32'h4002, d);
    $display("t_arm done");
  end
  endtask
  task t_busy;
  begin
    lat <= 4'hf;
    s = n_start;
    go_op(32'h100, 4'h1);
    xfer(1'b0, 8'h00, 32'h0);
    chk("busy", 32'hc001, d);
    chk("op out", 32'h1, {28'h0, FLASH_OP});
    chk("addr out", 32'h100, FLASH_ADDR);
    unl;
    xfer(1'b1, 8'h00, 32'h4001);
    xfer(1'b0, 8'h00, 32'h0);
    chk("go held", 32'hc001, d);
    idle;
    chk("ok", 32'h4001, d);
    chk("starts", s + 1, n_start);
    $display("t_busy done");
  end
  endtask
  task t_fail;
  begin
    lat <= 4'h2;
    bad <= 1'b1;
    LOW_SUPPLY <= 1'b1;
    xfer(1'b1, 8'h14, 32'h7);
    go_op(32'h200, 4'h1);
    idle;
    chk("errs", 32'h7001, d);
    bad <= 1'b0;
    LOW_SUPPLY <= 1'b0;
    #1 chk("irq", 32'h1, {31'h0, IRQ});
    xfer(1'b0, 8'h10, 32'h0);
    chk("status", 32'h7, d);
    #1 chk("irq clr", 32'h0, {31'h0, IRQ});
    pulse_rst;
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b0, 8'h00, 32'h0);
    chk("sticky", 32'h3001, d);
    go_op(32'h0, 4'h0);
    idle;
    chk("nop", 32'h4000, d);
    $display("t_fail done");
  end
  endtask
  task t_guard;
  begin
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b0, 8'h08, 32'h0);
    chk("no key", 32'h8700, d);
    s = n_start;
    go_op(tbl[2], 4'h1);
    idle;
    chk("p1 on", s, n_start);
    unl;
    xfer(1'b1, 8'h08, 32'h8500);
    xfer(1'b0, 8'h08, 32'h0);
    chk("pages", 32'h8500, d);
    for (k = 0; k < 7; k = k + 1)
    begin
      go_op(32'h0, 4'h0);
      idle;
      s = n_start;
      go_op(tbl[k], 4'h1);
      idle;
      chk("page", (k % 4 < 2 && k < 6) ? 32'h6001 : 32'h4001, d);
      chk("start", (k % 4 < 2 && k < 6) ? s : s + 1, n_start);
    end
    unl;
    xfer(1'b1, 8'h08, 32'h0);
    unl;
    xfer(1'b1, 8'h08, 32'h8700);
    xfer(1'b0, 8'h08, 32'h0);
    chk("latched", 32'h0, d);
    pulse_rst;
    xfer(1'b0, 8'h08, 32'h0);
    chk("relatch", 32'h8700, d);
    $display("t_guard done");
  end
  endtask
  initial
  begin
    repeat (10) @(posedge MCLK);
    POR <= 1'b0;
    RST <= 1'b0;
    t_reset;
    t_arm;
    t_busy;
    t_fail;
    t_guard;
    wrap_up;
  end
endmodule // flash_op_control_boot_guard_bench
